// [logic/vpm_core.sv]
`timescale 1ns/1ns
// Summary of operation
// - Second pattern group drives outputs on gate line
// - Gate line: region pattern, then field second group
// - Insertion enable bit controls special second pattern
// - Twelve-bit field picks the insertion line
// - Insertion pattern select and start pixel
// - Sweep region ignores line boundaries
// - Without sweep, train cut at line end
// - Pulse repeats the programmed repetition count
// - Normal line operation resumes after sweep region
// - Scaled toggle equals toggle times length
// - Region flag selects scaled or plain toggles
// - Start polarity and toggles kept when scaled
// - Scaled toggles move in pattern-length steps
// - Sweep plus scale lets pulses span lines
// - Boundary lines split field, selector picks sequence
module vpm_core
  import vpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing configuration
  input vpm_pattern_s patterns [NUM_PAT],
  input vpm_sequence_s sequences [NUM_SEQ],
  input vpm_region_s regions [NUM_REG],
  input vpm_field_s field,
  // Field start from the field sequencer
  input wire logic field_sync,
  input wire logic field_enable,
  // Vertical outputs and status
  output logic [NUM_XV-1:0] vertical_transfer_outputs,
  output logic horizontal_line_sync,
  output logic [LINE_W-1:0] line_count,
  output logic [REG_W-1:0] region_index,
  output logic gate_line_flag,
  output logic sweep_active
);

  vpm_state_e state;
  vpm_state_e next_state;
  logic [PIX_W-1:0] pix;
  logic [PIX_W-1:0] next_pix;
  logic [LINE_W-1:0] next_line;
  logic [REG_W-1:0] next_region;
  vpm_train_s first_train;
  vpm_train_s next_first_train;
  vpm_train_s second_train;
  vpm_train_s next_second_train;
  vpm_train_s second_now;
  logic second_on;
  logic next_second_on;
  logic [NUM_XV-1:0] next_xv;

  // Boundary lines in ascending order; later regions win
  function automatic logic [REG_W-1:0] region_of(
    input logic [LINE_W-1:0] line,
    input vpm_region_s regs [NUM_REG]
  );
    logic [REG_W-1:0] idx;
    idx = RST_REGION;
    for (int i = 1; i < NUM_REG; i++) begin
      if (line >= regs[i].region_boundary_line) begin
        idx = REG_W'(i);
      end
    end
    return idx;
  endfunction : region_of

  // Zero length is treated as one pixel to avoid a stuck phase
  function automatic vpm_train_s train_step(
    input vpm_train_s t,
    input logic [PIX_W-1:0] len,
    input logic [REP_W-1:0] reps
  );
    vpm_train_s n;
    n = t;
    if (t.active) begin
      if (t.phase + 13'h0001 >= len) begin
        n.phase = RST_PIX;
        n.unit = t.unit + 12'h001;
        n.active = (t.unit + 12'h001) < reps;
      end else begin
        n.phase = t.phase + 13'h0001;
      end
    end
    return n;
  endfunction : train_step

  function automatic vpm_train_s train_start(input logic [REP_W-1:0] reps);
    vpm_train_s n;
    n = RST_TRAIN;
    n.active = reps != 12'h000;
    return n;
  endfunction : train_start

  // Selection for the current region
  vpm_region_s cur_region;
  vpm_sequence_s cur_seq;
  vpm_pattern_s first_pat;
  vpm_region_s new_region;
  vpm_sequence_s new_seq;
  assign cur_region = regions[region_index];
  assign cur_seq = sequences[cur_region.region_sequence_select];
  assign first_pat = patterns[cur_seq.pattern_select];

  wire running = state == VPM_ACTIVE;
  wire line_end = running && (pix + 13'h0001 >= cur_seq.line_length);
  wire [LINE_W-1:0] line_plus = line_count + 12'h001;
  wire [REG_W-1:0] region_plus = region_of(line_plus, regions);
  assign new_region = regions[region_plus];
  assign new_seq = sequences[new_region.region_sequence_select];

  // Sweep keeps the train across a line only inside the same region
  wire sweep_keep = cur_region.sweep_enable && (region_plus == region_index);

  // Second group: the gate line wins if software puts both on one line
  wire on_gate_line = running && (line_count == field.gate_line);
  wire on_special_line = running && cur_seq.special_insert_enable &&
    (line_count == cur_seq.special_insert_line);
  wire second_line = on_gate_line || on_special_line;
  wire [SEL_W-1:0] second_sel = on_gate_line ? field.gate_line_second_group_select :
    cur_seq.special_insert_pattern_select;
  wire [PIX_W-1:0] second_start = on_gate_line ? field.gate_line_second_group_start :
    cur_seq.special_insert_start_pixel;
  wire second_go = second_line && !second_on && (pix == second_start);
  vpm_pattern_s second_pat;
  assign second_pat = patterns[second_sel];

  // Inserted pattern runs one pass of its own length
  assign second_now = second_go ? train_start(12'h001) : second_train;

  logic [NUM_XV-1:0] first_level;
  logic [NUM_XV-1:0] second_level;

  vpm_pattern_gen u_first (
    .clk(clk),
    .rst(rst),
    .pattern(first_pat),
    .train(first_train),
    .scale(cur_region.region_scale_enable),
    .level(first_level)
  );

  vpm_pattern_gen u_second (
    .clk(clk),
    .rst(rst),
    .pattern(second_pat),
    .train(second_now),
    .scale(1'b0),
    .level(second_level)
  );

  // Field sequencing
  always_comb begin
    next_state = state;
    case (state)
      VPM_IDLE: begin
        if (field_sync && field_enable) begin
          next_state = VPM_ACTIVE;
        end
      end
      VPM_ACTIVE: begin
        if (!field_enable) begin
          next_state = VPM_IDLE;
        end
      end
      default: next_state = VPM_IDLE;
    endcase
  end

  // Pixel and line counting
  always_comb begin
    next_pix = RST_PIX;
    next_line = line_count;
    next_region = region_index;
    if (field_sync || !running) begin
      next_line = RST_LINE;
      next_region = region_of(RST_LINE, regions);
    end else if (line_end) begin
      next_line = line_plus;
      next_region = region_plus;
    end else begin
      next_pix = pix + 13'h0001;
    end
  end

  // First group train
  always_comb begin
    next_first_train = train_step(first_train, first_pat.pattern_length_factor,
      cur_seq.pattern_repeat_count);
    if (field_sync || !running) begin
      next_first_train = train_start(sequences[regions[region_of(RST_LINE, regions)]
        .region_sequence_select].pattern_repeat_count);
    end else if (line_end && !sweep_keep) begin
      next_first_train = train_start(new_seq.pattern_repeat_count);
    end
  end

  // Second group train and its ownership of the outputs
  always_comb begin
    next_second_train = train_step(second_now, second_pat.pattern_length_factor, 12'h001);
    next_second_on = second_on || second_go;
    if (line_end || field_sync || !running) begin
      next_second_train = RST_TRAIN;
      next_second_on = 1'b0;
    end
  end

  assign next_xv = (second_on || second_go) ? second_level : first_level;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= VPM_IDLE;
      pix <= RST_PIX;
      line_count <= RST_LINE;
      region_index <= RST_REGION;
      first_train <= RST_TRAIN;
      second_train <= RST_TRAIN;
      second_on <= 1'b0;
      vertical_transfer_outputs <= RST_XV;
    end else begin
      state <= next_state;
      pix <= next_pix;
      line_count <= next_line;
      region_index <= next_region;
      first_train <= next_first_train;
      second_train <= next_second_train;
      second_on <= next_second_on;
      vertical_transfer_outputs <= next_xv;
    end
  end

  assign horizontal_line_sync = line_end;
  assign gate_line_flag = on_gate_line;
  assign sweep_active = running && cur_region.sweep_enable;

  property p_line_wrap;
    @(posedge clk) disable iff (rst)
    (line_end && !field_sync && field_enable) |=> (pix == RST_PIX) &&
      (line_count == $past(line_plus));
  endproperty
  a_line_wrap: assert property (p_line_wrap)
    else $error("Pixel count did not wrap at line end");

  property p_cut_at_line;
    @(posedge clk) disable iff (rst)
    (line_end && !sweep_keep && !field_sync && field_enable) |=>
      (first_train.phase == RST_PIX) && (first_train.unit == 12'h000);
  endproperty
  a_cut_at_line: assert property (p_cut_at_line)
    else $error("Train not restarted at a plain line boundary");

  property p_sweep_carry;
    @(posedge clk) disable iff (rst)
    (line_end && sweep_keep && first_train.active && !field_sync && field_enable &&
      (first_train.phase + 13'h0001 < first_pat.pattern_length_factor)) |=>
      first_train.active && (first_train.unit == $past(first_train.unit)) &&
      (first_train.phase == $past(first_train.phase) + 13'h0001) &&
      (line_count == $past(line_count) + 12'h001);
  endproperty
  a_sweep_carry: assert property (p_sweep_carry)
    else $error("Sweep train reset at a line boundary");

  // Count taken at the step itself, since software may rewrite it mid-train
  property p_rep_bound;
    @(posedge clk) disable iff (rst)
    (first_train.active && running && !field_sync && !(line_end && !sweep_keep)) |=>
      !first_train.active || (first_train.unit == $past(first_train.unit)) ||
      (first_train.unit < $past(cur_seq.pattern_repeat_count));
  endproperty
  a_rep_bound: assert property (p_rep_bound)
    else $error("Train ran past its repetition count");

  property p_insert_off;
    @(posedge clk) disable iff (rst)
    (!cur_seq.special_insert_enable && (line_count != field.gate_line)) |-> !second_go;
  endproperty
  a_insert_off: assert property (p_insert_off)
    else $error("Second pattern started off its line");

  property p_second_holds;
    @(posedge clk) disable iff (rst)
    (second_on && !line_end && !field_sync && running) |=> second_on;
  endproperty
  a_second_holds: assert property (p_second_holds)
    else $error("Second pattern dropped before line end");

  property p_second_clears;
    @(posedge clk) disable iff (rst)
    line_end |=> !second_on ##1 (vertical_transfer_outputs == $past(first_level) ||
      $past(second_go));
  endproperty
  a_second_clears: assert property (p_second_clears)
    else $error("Second pattern survived into the next line");

  property p_second_start;
    @(posedge clk) disable iff (rst)
    second_go |-> (pix == second_start) ##1 (vertical_transfer_outputs == $past(second_level));
  endproperty
  a_second_start: assert property (p_second_start)
    else $error("Second group not driven from its start pixel");

  property p_first_drive;
    @(posedge clk) disable iff (rst)
    (!second_on && !second_go) |=> vertical_transfer_outputs == $past(first_level);
  endproperty
  a_first_drive: assert property (p_first_drive)
    else $error("First group not on outputs");

endmodule : vpm_core

// [logic/vpm_pkg.sv]
package vpm_pkg;

  localparam int NUM_XV = 13;
  localparam int PIX_W = 13;
  localparam int LINE_W = 12;
  localparam int SEL_W = 5;
  localparam int REP_W = 12;
  localparam int NUM_PAT = 32;
  localparam int NUM_SEQ = 32;
  localparam int NUM_REG = 7;
  localparam int REG_W = 3;

  // Values after reset
  localparam logic [PIX_W-1:0] RST_PIX = 13'h0000;
  localparam logic [LINE_W-1:0] RST_LINE = 12'h000;
  localparam logic [REG_W-1:0] RST_REGION = 3'h0;
  localparam logic [NUM_XV-1:0] RST_XV = 13'h0000;

  typedef struct packed {
    logic [NUM_XV-1:0] vertical_start_polarity;
    logic [NUM_XV-1:0][PIX_W-1:0] toggle_first;
    logic [NUM_XV-1:0][PIX_W-1:0] toggle_second;
    logic [PIX_W-1:0] pattern_length_factor;
  } vpm_pattern_s;

  typedef struct packed {
    logic [SEL_W-1:0] pattern_select;
    logic [REP_W-1:0] pattern_repeat_count;
    logic [PIX_W-1:0] line_length;
    logic special_insert_enable;
    logic [LINE_W-1:0] special_insert_line;
    logic [SEL_W-1:0] special_insert_pattern_select;
    logic [PIX_W-1:0] special_insert_start_pixel;
  } vpm_sequence_s;

  typedef struct packed {
    logic [LINE_W-1:0] region_boundary_line;
    logic [SEL_W-1:0] region_sequence_select;
    logic sweep_enable;
    logic region_scale_enable;
  } vpm_region_s;

  typedef struct packed {
    logic [LINE_W-1:0] gate_line;
    logic [SEL_W-1:0] gate_line_second_group_select;
    logic [PIX_W-1:0] gate_line_second_group_start;
  } vpm_field_s;

  // Progress of one pulse train
  typedef struct packed {
    logic active;
    logic [PIX_W-1:0] phase;
    logic [REP_W-1:0] unit;
  } vpm_train_s;

  localparam vpm_train_s RST_TRAIN = '0;

  typedef enum logic [1:0] {
    VPM_IDLE = 2'b00,
    VPM_ACTIVE = 2'b01
  } vpm_state_e;

endpackage : vpm_pkg

// [logic/vpm_pattern_gen.sv]
`timescale 1ns/1ns
module vpm_pattern_gen
  import vpm_pkg::*;
(
  // Clock and reset for the checks
  input wire logic clk,
  input wire logic rst,
  // Pattern and train position
  input vpm_pattern_s pattern,
  input vpm_train_s train,
  input wire logic scale,
  // Levels for the transfer outputs
  output logic [NUM_XV-1:0] level
);

  logic [PIX_W-1:0] position;
  logic [NUM_XV-1:0] past_first;
  logic [NUM_XV-1:0] past_second;

  // Scaled mode compares whole pattern lengths, so no multiplier is needed
  assign position = scale ? PIX_W'(train.unit) : train.phase;

  genvar g;
  generate
    for (g = 0; g < NUM_XV; g++) begin : g_xv
      assign past_first[g] = position >= pattern.toggle_first[g];
      assign past_second[g] = position >= pattern.toggle_second[g];
    end
  endgenerate

  // Idle train holds the start polarity
  assign level = train.active ?
    (pattern.vertical_start_polarity ^ past_first ^ past_second) :
    pattern.vertical_start_polarity;

  property p_scale_coarse;
    @(posedge clk) disable iff (rst)
    (scale && train.active) ##1
    (scale && train.active && $stable(train.unit) && $stable(pattern))
    |-> $stable(level);
  endproperty
  a_scale_coarse: assert property (p_scale_coarse)
    else $error("Scaled output moved inside one pattern length");

  property p_idle_polarity;
    @(posedge clk) disable iff (rst)
    !train.active |-> level == pattern.vertical_start_polarity;
  endproperty
  a_idle_polarity: assert property (p_idle_polarity)
    else $error("Idle train does not show start polarity");

endmodule : vpm_pattern_gen

// [tb/vpm_ccd_model.sv]
`timescale 1ns/1ns
module vpm_ccd_model
  import vpm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Gate drive from the block
  input wire logic [NUM_XV-1:0] xv,
  input wire logic line_sync,
  // Observation window
  input wire logic clr,
  input wire logic win,
  // Observed figures
  output logic [15:0] cnt_first,
  output logic [15:0] cnt_last,
  output logic [15:0] first_high,
  output logic [15:0] sync_cnt
);
  logic [15:0] idx;

  // Sensor gates only load; they count what they see inside the window
  always_ff @(posedge clk) begin
    if (clr) begin
      idx <= 16'h0000;
      cnt_first <= 16'h0000;
      cnt_last <= 16'h0000;
      sync_cnt <= 16'h0000;
      first_high <= 16'hffff;
    end else if (win) begin
      idx <= idx + 16'h0001;
      cnt_first <= cnt_first + 16'(xv[0]);
      cnt_last <= cnt_last + 16'(xv[NUM_XV-1]);
      sync_cnt <= sync_cnt + 16'(line_sync);
      if (xv[0] && first_high == 16'hffff) begin
        first_high <= idx;
      end
    end
  end
endmodule : vpm_ccd_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench
  import vpm_pkg::*;
;
  logic clk;
  logic rst;
  vpm_pattern_s patterns [NUM_PAT];
  vpm_sequence_s sequences [NUM_SEQ];
  vpm_region_s regions [NUM_REG];
  vpm_field_s field;
  logic field_sync;
  logic field_enable;
  logic [NUM_XV-1:0] xv;
  logic line_sync;
  logic [LINE_W-1:0] line_count;
  logic [REG_W-1:0] region_index;
  logic clr;
  logic win;
  logic [15:0] cnt_first;
  logic [15:0] cnt_last;
  logic [15:0] first_high;
  logic [15:0] sync_cnt;
  logic gate_flag;
  logic sweep_flag;
  logic [15:0] gate_cnt;
  logic [15:0] sweep_cnt;
  int error_cnt;
  int num_checks;

  vpm_core i_vpm_core (.clk(clk), .rst(rst), .patterns(patterns), .sequences(sequences),
    .regions(regions), .field(field), .field_sync(field_sync), .field_enable(field_enable),
    .vertical_transfer_outputs(xv), .horizontal_line_sync(line_sync),
    .line_count(line_count), .region_index(region_index), .gate_line_flag(gate_flag),
    .sweep_active(sweep_flag));

  vpm_ccd_model i_vpm_ccd_model (.clk(clk), .xv(xv), .line_sync(line_sync), .clr(clr),
    .win(win), .cnt_first(cnt_first), .cnt_last(cnt_last), .first_high(first_high),
    .sync_cnt(sync_cnt));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Status flags counted over the same window as the sensor model
  always @(posedge clk) begin
    if (clr) begin
      gate_cnt <= 16'h0000;
      sweep_cnt <= 16'h0000;
    end else if (win) begin
      gate_cnt <= gate_cnt + 16'(gate_flag);
      sweep_cnt <= sweep_cnt + 16'(sweep_flag);
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Quiet setup: no toggles inside any pattern length, all trains idle
  task automatic cfg_clear(input logic [PIX_W-1:0] len);
    for (int i = 0; i < NUM_PAT; i++) begin
      patterns[i].vertical_start_polarity = 13'h0000;
      patterns[i].toggle_first = {NUM_XV{13'h1fff}};
      patterns[i].toggle_second = {NUM_XV{13'h1fff}};
      patterns[i].pattern_length_factor = 13'h0001;
    end
    patterns[2].vertical_start_polarity = 13'h1fff;
    for (int i = 0; i < NUM_SEQ; i++) begin
      sequences[i] = '0;
      sequences[i].line_length = len;
    end
    for (int i = 0; i < NUM_REG; i++) begin
      regions[i] = '0;
      regions[i].region_boundary_line = 12'hfff;
    end
    field.gate_line = 12'hfff;
    field.gate_line_second_group_select = 5'h02;
    field.gate_line_second_group_start = 13'h0000;
  endtask : cfg_clear

  // Start a field, then watch n pixels from pixel 0 on
  task automatic run(input int n);
    @(posedge clk);
    #1 field_sync = 1'b1;
    clr = 1'b1;
    @(posedge clk);
    #1 field_sync = 1'b0;
    clr = 1'b0;
    @(posedge clk);
    #1 win = 1'b1;
    repeat (n) @(posedge clk);
    #1 win = 1'b0;
  endtask : run

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst = 1'b1;
    field_sync = 1'b0;
    field_enable = 1'b0;
    clr = 1'b1;
    win = 1'b0;
    cfg_clear(13'h000a);
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    check("reset outputs", 16'(xv), 16'(RST_XV));
    check("reset line", 16'(line_count), 16'(RST_LINE));
    check("reset region", 16'(region_index), 16'(RST_REGION));
    // Start request while disabled is ignored
    run(30);
    check("disabled syncs", sync_cnt, 16'h0000);
    field_enable = 1'b1;
    // Sweep region 0 then plain region 1 from line 4
    patterns[0].toggle_first[0] = 13'h0002;
    patterns[0].toggle_second[0] = 13'h0005;
    patterns[0].pattern_length_factor = 13'h0008;
    patterns[1].toggle_first[NUM_XV-1] = 13'h0002;
    patterns[1].toggle_second[NUM_XV-1] = 13'h0005;
    patterns[1].pattern_length_factor = 13'h0008;
    sequences[0].pattern_repeat_count = 12'h003;
    sequences[1].pattern_select = 5'h01;
    sequences[1].pattern_repeat_count = 12'h001;
    regions[0].sweep_enable = 1'b1;
    regions[1].region_boundary_line = 12'h004;
    regions[1].region_sequence_select = 5'h01;
    run(60);
    check("sweep train highs", cnt_first, 16'h0009);
    check("sweep first high", first_high, 16'h0002);
    check("after sweep highs", cnt_last, 16'h0006);
    check("region index", 16'(region_index), 16'h0001);
    check("sweep flag", sweep_cnt, 16'h0027);
    regions[0].sweep_enable = 1'b0;
    run(60);
    check("cut train highs", cnt_first, 16'h000c);
    check("line syncs", sync_cnt, 16'h0006);
    check("no sweep flag", sweep_cnt, 16'h0000);
    // Scaled wide pulse across lines
    cfg_clear(13'h000a);
    patterns[3].toggle_first[0] = 13'h0002;
    patterns[3].toggle_second[0] = 13'h0009;
    patterns[3].pattern_length_factor = 13'h0004;
    sequences[0].pattern_select = 5'h03;
    sequences[0].pattern_repeat_count = 12'h009;
    regions[0].sweep_enable = 1'b1;
    regions[0].region_scale_enable = 1'b1;
    regions[1].region_boundary_line = 12'h008;
    regions[1].region_sequence_select = 5'h02;
    run(80);
    check("scaled first toggle", first_high, 16'h0008);
    check("scaled pulse width", cnt_first, 16'h001c);
    check("scaled sweep flag", sweep_cnt, 16'h004f);
    // Second group on the gate line
    cfg_clear(13'h0014);
    field.gate_line = 12'h001;
    field.gate_line_second_group_start = 13'h0005;
    run(60);
    check("gate second first", first_high, 16'h0019);
    check("gate second low out", cnt_first, 16'h000f);
    check("gate second high out", cnt_last, 16'h000f);
    check("gate line flag", gate_cnt, 16'h0014);
    // Special insertion kept off the gate line
    field.gate_line = 12'hfff;
    sequences[0].special_insert_enable = 1'b1;
    sequences[0].special_insert_line = 12'h002;
    sequences[0].special_insert_pattern_select = 5'h02;
    sequences[0].special_insert_start_pixel = 13'h0008;
    run(80);
    check("insert first", first_high, 16'h0030);
    check("insert highs", cnt_first, 16'h000c);
    sequences[0].special_insert_enable = 1'b0;
    run(80);
    check("insert disabled", cnt_first, 16'h0000);
    // Dropping the enable must stop line timing
    field_enable = 1'b0;
    run(20);
    check("idle syncs", sync_cnt, 16'h0000);
    conclude();
  end
endmodule : testbench
